// >>> hdl/acr_defs.svh
// constants of the converter control block: register offsets, field positions, reset values, timing
// assumes inclusion by bare name from the package and the design modules
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_OFS_STATUS_CONTROL_ONE 12'h000
`define ACR_OFS_MODE_CONFIG 12'h004
`define ACR_OFS_RESULT_HIGH 12'h008
`define ACR_OFS_RESULT_LOW 12'h00C
`define ACR_CH_LSB 0
`define ACR_CH_MSB 4
`define ACR_CONT_BIT 5
`define ACR_IE_BIT 6
`define ACR_FLAG_BIT 7
`define ACR_MODE_LSB 0
`define ACR_MODE_MSB 1
`define ACR_CLKSEL_BIT 2
`define ACR_CH_OFF 5'h1F
`define ACR_CTRL_RESET 7'h1F
`define ACR_MODE_RESET 2'h0
`define ACR_CONV_CYCLES 16
`define ACR_SAMPLE_W 12
`endif

// >>> hdl/acr_pkg.sv
// types shared by the converter control block
// assumes acr_defs.svh on the include path
`include "acr_defs.svh"
package acr_pkg;
   typedef enum logic [1:0] {
      ACR_MODE_8 = 2'h0,
      ACR_MODE_10 = 2'h1,
      ACR_MODE_12 = 2'h2,
      ACR_MODE_RSV = 2'h3
   } acr_mode_e;
   typedef struct packed {
      logic int_enable;
      logic continuous;
      logic [4:0] channel;
   } acr_ctrl_s;
   typedef enum logic [1:0] {
      ACR_ST_IDLE = 2'b01,
      ACR_ST_RUN = 2'b10
   } acr_state_e;
endpackage

// >>> hdl/acr_conv_core.sv
// conversion sequencer: counts conversion clock ticks and hands back one sample per conversion
// assumes tick and sample are already in the pclk domain
`timescale 1ns/1ps
`include "acr_defs.svh"
module acr_conv_core
   import acr_pkg::*;
#(
   parameter int CONV_CYCLES = `ACR_CONV_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic stop,
   input wire logic continuous,
   input wire logic tick,
   input wire logic [`ACR_SAMPLE_W-1:0] sample,
   output logic done,
   output logic [`ACR_SAMPLE_W-1:0] data
);
   // the tick counter is 16 bits wide
   if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_cycles
      $error("acr_conv_core: CONV_CYCLES out of range");
   end
   acr_state_e state;
   logic [15:0] count;
   logic last;
   assign last = tick && (count == 16'(CONV_CYCLES - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ACR_ST_IDLE;
         count <= 16'h0000;
      end else if (start) begin
         // a control write restarts the sequence on the new channel
         state <= ACR_ST_RUN;
         count <= 16'h0000;
      end else if (stop) begin
         state <= ACR_ST_IDLE;
         count <= 16'h0000;
      end else begin
         unique case (state)
            ACR_ST_IDLE: begin
               count <= 16'h0000;
            end
            ACR_ST_RUN: begin
               if (last) begin
                  count <= 16'h0000;
                  state <= continuous ? ACR_ST_RUN : ACR_ST_IDLE;
               end else if (tick) begin
                  count <= count + 16'h0001;
               end
            end
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
         data <= 12'h000;
      end else begin
         done <= (state == ACR_ST_RUN) && last && !start && !stop;
         if ((state == ACR_ST_RUN) && last) begin
            data <= sample;
         end
      end
   end
endmodule

// >>> hdl/acr_top.sv
// converter control, completion flag and coherent result read-out behind an APB slave
// assumes an APB master on pclk; conversion clock pin and sample pins are asynchronous
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "acr_defs.svh"
// Overview of operation
// - control write clears flag; late completion survives
// - interrupt follows flag and enable after write
// - high byte read freezes low byte outside eight-bit mode
// - high read during completion keeps older low
// - eight-bit mode reads whole result directly
// - single mode keeps result until restart
// - conversion clock from bus or asynchronous pin
// - continuous mode; control write retargets sequence
module acr_top
   import acr_pkg::*;
#(
   parameter int CONV_CYCLES = `ACR_CONV_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_clk_pin,
   input wire logic [`ACR_SAMPLE_W-1:0] sample_pin,
   output logic [4:0] channel_select,
   output logic conversion_irq
);
   // the sequencer counts conversion ticks in 16 bits
   if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_cycles
      $error("acr_top: CONV_CYCLES out of range");
   end

   acr_ctrl_s converter_status_control_one;
   acr_mode_e mode;
   logic clock_select;
   logic conversion_complete_flag;
   logic [11:0] conversion_result_register;
   logic [7:0] low_frozen;
   logic low_is_frozen;
   logic clk_s1, clk_s2, clk_s3;
   logic [`ACR_SAMPLE_W-1:0] samp_s1, samp_s2, samp_s3;
   logic [`ACR_SAMPLE_W-1:0] samp_held;
   logic tick;
   logic conv_done;
   logic [11:0] conv_data;
   logic setup, access;
   logic wr_ctrl, wr_mode, rd_high, rd_low;
   logic [7:0] res_high, res_low;
   logic [11:0] next_result;
   logic mapped;

   // two-stage synchronisers plus a third stage; the second and third stages feed logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
         samp_s1 <= 12'h000;
         samp_s2 <= 12'h000;
         samp_s3 <= 12'h000;
      end else begin
         clk_s1 <= conv_clk_pin;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         samp_s1 <= sample_pin;
         samp_s2 <= samp_s1;
         samp_s3 <= samp_s2;
      end
   end

   // the sample word crosses as a plain bus; it is taken only when two successive copies agree,
   // so bits caught mid-change never reach the result; a pin that never settles keeps the old word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_held <= 12'h000;
      end else if (samp_s2 == samp_s3) begin
         samp_held <= samp_s2;
      end
   end

   // asynchronous conversion clock is seen as its rising edges; pin must run below pclk/2
   // on the bus clock every cycle is a conversion tick
   assign tick = clock_select ? (clk_s2 && !clk_s3) : 1'b1;

   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign wr_ctrl = access && pwrite && (paddr == `ACR_OFS_STATUS_CONTROL_ONE);
   assign wr_mode = access && pwrite && (paddr == `ACR_OFS_MODE_CONFIG);
   // read side effects act at setup, the same edge that captures read data
   assign rd_high = setup && !pwrite && (paddr == `ACR_OFS_RESULT_HIGH);
   assign rd_low = setup && !pwrite && (paddr == `ACR_OFS_RESULT_LOW);
   // only the four aligned words decode; anything else is refused
   assign mapped = (paddr == `ACR_OFS_STATUS_CONTROL_ONE) || (paddr == `ACR_OFS_MODE_CONFIG) ||
                   (paddr == `ACR_OFS_RESULT_HIGH) || (paddr == `ACR_OFS_RESULT_LOW);

   acr_conv_core #(
      .CONV_CYCLES(CONV_CYCLES)
   ) u_core (
      .pclk(pclk),
      .presetn(presetn),
      .start(wr_ctrl && (pwdata[`ACR_CH_MSB:`ACR_CH_LSB] != `ACR_CH_OFF)),
      .stop(wr_ctrl && (pwdata[`ACR_CH_MSB:`ACR_CH_LSB] == `ACR_CH_OFF)),
      .continuous(converter_status_control_one.continuous),
      .tick(tick),
      .sample(samp_held),
      .done(conv_done),
      .data(conv_data)
   );

   // result is right aligned at the width of the selected mode
   always_comb begin
      unique case (mode)
         ACR_MODE_8: next_result = {4'h0, conv_data[11:4]};
         ACR_MODE_10: next_result = {2'h0, conv_data[11:2]};
         default: next_result = conv_data;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_status_control_one <= acr_ctrl_s'(`ACR_CTRL_RESET);
         channel_select <= `ACR_CH_OFF;
      end else if (wr_ctrl) begin
         converter_status_control_one.channel <= pwdata[`ACR_CH_MSB:`ACR_CH_LSB];
         converter_status_control_one.continuous <= pwdata[`ACR_CONT_BIT];
         converter_status_control_one.int_enable <= pwdata[`ACR_IE_BIT];
         channel_select <= pwdata[`ACR_CH_MSB:`ACR_CH_LSB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= acr_mode_e'(`ACR_MODE_RESET);
         clock_select <= 1'b0;
      end else if (wr_mode) begin
         mode <= acr_mode_e'(pwdata[`ACR_MODE_MSB:`ACR_MODE_LSB]);
         clock_select <= pwdata[`ACR_CLKSEL_BIT];
      end
   end

   // result only moves on a completed conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_result_register <= 12'h000;
      end else if (conv_done) begin
         conversion_result_register <= next_result;
      end
   end

   // completion beats the clear of a control write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_complete_flag <= 1'b0;
      end else if (conv_done) begin
         conversion_complete_flag <= 1'b1;
      end else if (wr_ctrl) begin
         conversion_complete_flag <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_irq <= 1'b0;
      end else begin
         // follows the registered flag, so a flag kept by a late completion fires right after the write
         conversion_irq <= conversion_complete_flag && converter_status_control_one.int_enable;
      end
   end

   // low byte latch: captures the pre-update value, so a completion in the read cycle cannot mix bytes
   // limitation: a second high read before the low read latches again and drops the first pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_frozen <= 8'h00;
         low_is_frozen <= 1'b0;
      end else if (rd_high && (mode != ACR_MODE_8)) begin
         low_frozen <= conversion_result_register[7:0];
         low_is_frozen <= 1'b1;
      end else if (rd_low || (mode == ACR_MODE_8)) begin
         low_is_frozen <= 1'b0;
      end
   end

   assign res_high = (mode == ACR_MODE_8) ? 8'h00 : {4'h0, conversion_result_register[11:8]};
   assign res_low = low_is_frozen ? low_frozen : conversion_result_register[7:0];

   // answer registered: pready rises in the first access cycle
   // every setup is answered at once, so there are no wait states; unmapped offsets read as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         if (setup && !pwrite) begin
            unique case (paddr)
               `ACR_OFS_STATUS_CONTROL_ONE: begin
                  prdata <= {24'h000000, conversion_complete_flag,
                             converter_status_control_one.int_enable,
                             converter_status_control_one.continuous,
                             converter_status_control_one.channel};
               end
               `ACR_OFS_MODE_CONFIG: prdata <= {29'h0, clock_select, mode};
               `ACR_OFS_RESULT_HIGH: prdata <= {24'h000000, res_high};
               `ACR_OFS_RESULT_LOW: prdata <= {24'h000000, res_low};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// >>> test/acr_top_monitor.sv
// port-level assertions for the converter control block
// assumes it is bound onto acr_top; one clock domain, pclk
`timescale 1ns/1ps
module acr_top_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic conv_clk_pin,
   input wire logic [11:0] sample_pin,
   input wire logic [4:0] channel_select,
   input wire logic conversion_irq
);
   wire logic wr_ctl = psel && penable && pready && pwrite && (paddr == 12'h000);
   wire logic [4:0] wr_chan = pwdata[4:0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   chk_err_unmapped: assert property (psel && !penable && paddr > 12'h00C |=> pslverr)
      else $error("unmapped address not refused");
   chk_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   chk_channel_follow: assert property (wr_ctl |=> channel_select == $past(wr_chan))
      else $error("channel not taken from control write");
   chk_channel_hold: assert property (!wr_ctl |=> $stable(channel_select))
      else $error("channel changed without control write");
   chk_irq_off_write: assert property (wr_ctl && !pwdata[6] |=> ##1 !conversion_irq)
      else $error("interrupt stayed up after disabling write");
endmodule
bind acr_top acr_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .conv_clk_pin(conv_clk_pin), .sample_pin(sample_pin), .channel_select(channel_select),
   .conversion_irq(conversion_irq));

// >>> test/test_adc_control_result_coherency.sv
// self-checking bench for the converter control block over APB
// assumes acr_top with a short conversion count; conversion pin clock made here
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module test_adc_control_result_coherency;
   import acr_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_clk_pin = 0, pslverr, pready;
   logic conversion_irq;
   logic [11:0] paddr = 12'h000;
   logic [11:0] sample_pin = 12'hA5C;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [4:0] channel_select;
   logic [1:0] div = 2'h0;
   logic er;
   int error_cnt = 0, cmp_count = 0;
   acr_top #(.CONV_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_clk_pin(conv_clk_pin), .sample_pin(sample_pin), .channel_select(channel_select),
      .conversion_irq(conversion_irq));
   always #20 pclk = ~pclk;
   // pin clock at a sixth of pclk keeps well below the synchroniser's limit
   always @(posedge pclk) begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h2) conv_clk_pin <= ~conv_clk_pin;
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      // only the watchdog ends this wait
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic wait_flag();
      int n;
      n = 0;
      apb(0, 12'h000, 0);
      while (rd[7] !== 1'b1 && n < 100) begin n++; apb(0, 12'h000, 0); end
      if (n == 100) error_cnt++;
   endtask
   task automatic t_reset();
      `CHK("channel", 5'h1F, channel_select)
      `CHK("irq", 1'b0, conversion_irq)
      apb(0, 12'h000, 0); `CHK("ctrl", 32'h1F, rd)
      apb(0, 12'h004, 0); `CHK("mode", 32'h0, rd)
      apb(0, 12'h010, 0); `CHK("err", 1'b1, er)
      `CHK("err data", 32'h0, rd)
      apb(1, 12'h010, 32'h3); apb(0, 12'h000, 0); `CHK("ctrl kept", 32'h1F, rd)
   endtask
   task automatic t_single(input logic [31:0] mode);
      int n;
      n = 0;
      apb(1, 12'h004, mode);
      apb(1, 12'h000, 32'h43);
      // the write edge is also the edge that launches channel_select; look once it has settled
      @(negedge pclk);
      `CHK("channel", 5'h03, channel_select)
      while (conversion_irq !== 1'b1 && n < 200) begin n++; @(posedge pclk); end
      apb(0, 12'h000, 0); `CHK("flag", 32'hC3, rd)
      `CHK("irq", 1'b1, conversion_irq)
      sample_pin <= 12'h3C7;
      repeat (30) @(posedge pclk);
      apb(0, 12'h008, 0); `CHK("high", 32'hA, rd)
      apb(0, 12'h00C, 0); `CHK("low", 32'h5C, rd)
      apb(1, 12'h000, 32'h1F);
      repeat (2) @(posedge pclk);
      `CHK("irq off", 1'b0, conversion_irq)
      apb(0, 12'h000, 0); `CHK("flag clear", 32'h1F, rd)
      sample_pin <= 12'hA5C;
   endtask
   task automatic t_freeze();
      apb(1, 12'h004, 32'h1);
      apb(1, 12'h000, 32'h23); wait_flag();
      repeat (30) @(posedge pclk);
      apb(0, 12'h008, 0); `CHK("high10", 32'h2, rd)
      sample_pin <= 12'h3C7;
      repeat (30) @(posedge pclk);
      apb(0, 12'h00C, 0); `CHK("low frozen", 32'h97, rd)
      apb(0, 12'h008, 0); `CHK("high new", 32'h0, rd)
      apb(0, 12'h00C, 0); `CHK("low new", 32'hF1, rd)
      apb(1, 12'h000, 32'h1F);
   endtask
   task automatic t_eight();
      apb(1, 12'h004, 32'h0);
      apb(1, 12'h000, 32'h03); wait_flag();
      apb(0, 12'h008, 0); `CHK("high8", 32'h0, rd)
      apb(0, 12'h00C, 0); `CHK("low8", 32'h3C, rd)
      // channel change the safe way: off with interrupts masked, then the new channel
      apb(1, 12'h000, 32'h1F);
      apb(1, 12'h000, 32'h44);
      @(negedge pclk);
      `CHK("channel two-step", 5'h04, channel_select)
      wait_flag();
      `CHK("flag two-step", 32'hC4, rd)
      `CHK("irq two-step", 1'b1, conversion_irq)
   endtask
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset();
      t_single(32'h2);
      t_single(32'h6);
      t_freeze();
      t_eight();
      tally_and_finish();
   end
   initial begin
      #(40 * 20000);
      error_cnt++;
      tally_and_finish();
   end
endmodule
